// ---- hw/quadrature_decoder_defines.svh ----
`ifndef QUADRATURE_DECODER_DEFINES_SVH
`define QUADRATURE_DECODER_DEFINES_SVH

// register byte offsets
`define OFS_TASK_START 12'h000
`define OFS_TASK_STOP 12'h004
`define OFS_TASK_CLR_BOTH 12'h008
`define OFS_TASK_CLR_MOTION 12'h00c
`define OFS_TASK_CLR_DOUBLES 12'h010
`define OFS_EV_SAMPLE_READY 12'h100
`define OFS_EV_REPORT_READY 12'h104
`define OFS_EV_OVERFLOW 12'h108
`define OFS_EV_DOUBLE_READY 12'h10c
`define OFS_EV_HALTED 12'h110
`define OFS_LINKS 12'h200
`define OFS_IRQ_SET 12'h304
`define OFS_IRQ_CLR 12'h308
`define OFS_SAMPLE 12'h50c
`define OFS_REPORT_PERIOD 12'h510
`define OFS_MOTION 12'h514
`define OFS_MOTION_SNAP 12'h518
`define OFS_DOUBLE_COUNT 12'h544
`define OFS_DOUBLE_SNAP 12'h548

// event bit positions, shared by event, mask and irq registers
`define EV_SAMPLE 0
`define EV_REPORT 1
`define EV_OVERFLOW 2
`define EV_DOUBLE 3
`define EV_HALTED 4
`define EV_NUM 5

// link bit positions
`define LNK_REPORT_CLR_BOTH 0
`define LNK_SAMPLE_STOP 1
`define LNK_REPORT_CLR_MOTION 2
`define LNK_REPORT_STOP 3
`define LNK_DOUBLE_CLR_DOUBLES 4
`define LNK_DOUBLE_STOP 5
`define LNK_SAMPLE_CLR_BOTH 6
`define LNK_NUM 7

// report period codes and sample counts
`define RP_CODE_W 4
`define RP_CNT_W 9
`define RP_CODE_ONE 4'h8
`define RP_SAMPLES_C0 9'd10
`define RP_SAMPLES_C1 9'd40
`define RP_SAMPLES_C2 9'd80
`define RP_SAMPLES_C3 9'd120
`define RP_SAMPLES_C4 9'd160
`define RP_SAMPLES_C5 9'd200
`define RP_SAMPLES_C6 9'd240
`define RP_SAMPLES_C7 9'd280
`define RP_SAMPLES_ONE 9'd1
`define RP_RESET 4'h0

// sample encoding from the sampler core
`define SAMPLE_DOUBLE 2'b10
`define SAMPLE_DOUBLE_READ 32'h0000_0002

`define REG_RESET 32'h0000_0000

`endif

// ---- hw/quadrature_decoder_events.sv ----
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "quadrature_decoder_defines.svh"

module quadrature_decoder_events
   import quadrature_decoder_pkg::*;
#(
   parameter int ACC_W = 11,
   parameter int DBL_W = 4
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // sampler core
   input wire logic SAMPLE_STB,
   input wire logic [1:0] SAMPLE_VAL,
   input wire logic CORE_HALTED,
   output logic DECODER_RUN,
   // interrupt
   output logic IRQ
);

   function automatic logic wr_to(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction

   function automatic logic [`RP_CNT_W-1:0] period_samples(input logic [`RP_CODE_W-1:0] code);
      logic [`RP_CNT_W-1:0] n;
      n = `RP_SAMPLES_C0;
      case (code)
         4'h1: n = `RP_SAMPLES_C1;
         4'h2: n = `RP_SAMPLES_C2;
         4'h3: n = `RP_SAMPLES_C3;
         4'h4: n = `RP_SAMPLES_C4;
         4'h5: n = `RP_SAMPLES_C5;
         4'h6: n = `RP_SAMPLES_C6;
         4'h7: n = `RP_SAMPLES_C7;
         `RP_CODE_ONE: n = `RP_SAMPLES_ONE;
         default: n = `RP_SAMPLES_C0;
      endcase
      return n;
   endfunction

   // state
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [`EV_NUM-1:0] ev_reg;
   logic [`EV_NUM-1:0] ev_next;
   logic [`EV_NUM-1:0] ev_pulse_reg;
   logic [`EV_NUM-1:0] mask_reg;
   logic [`EV_NUM-1:0] mask_next;
   logic [`LNK_NUM-1:0] link_reg;
   logic [`RP_CODE_W-1:0] period_reg;
   logic [`RP_CNT_W-1:0] rp_cnt_reg;
   logic [`RP_CNT_W-1:0] rp_cnt_next;
   logic signed [ACC_W-1:0] acc_reg;
   logic signed [ACC_W-1:0] acc_next;
   logic signed [ACC_W-1:0] snap_acc_reg;
   logic [DBL_W-1:0] dbl_reg;
   logic [DBL_W-1:0] dbl_next;
   logic [DBL_W-1:0] snap_dbl_reg;
   logic [1:0] sample_reg;
   logic irq_reg;
   logic run_reg;
   run_state_t state_reg;
   run_state_t state_next;

   // apb decode: writes land at the access edge, which is the only edge with pready high
   wire apb_setup = PSEL & ~PENABLE;
   wire apb_wr = PSEL & PENABLE & PWRITE & pready_reg;
   wire wr_one = apb_wr & PWDATA[0];

   wire [`EV_NUM-1:0] wr_ev;
   assign wr_ev[`EV_SAMPLE] = apb_wr & wr_to(PADDR, `OFS_EV_SAMPLE_READY);
   assign wr_ev[`EV_REPORT] = apb_wr & wr_to(PADDR, `OFS_EV_REPORT_READY);
   assign wr_ev[`EV_OVERFLOW] = apb_wr & wr_to(PADDR, `OFS_EV_OVERFLOW);
   assign wr_ev[`EV_DOUBLE] = apb_wr & wr_to(PADDR, `OFS_EV_DOUBLE_READY);
   assign wr_ev[`EV_HALTED] = apb_wr & wr_to(PADDR, `OFS_EV_HALTED);

   wire wr_links = apb_wr & wr_to(PADDR, `OFS_LINKS);
   wire wr_mset = apb_wr & wr_to(PADDR, `OFS_IRQ_SET);
   wire wr_mclr = apb_wr & wr_to(PADDR, `OFS_IRQ_CLR);
   wire wr_period = apb_wr & wr_to(PADDR, `OFS_REPORT_PERIOD);

   // links act on the event one cycle after it is raised
   wire p_smp = ev_pulse_reg[`EV_SAMPLE];
   wire p_rep = ev_pulse_reg[`EV_REPORT];
   wire p_dbl = ev_pulse_reg[`EV_DOUBLE];

   wire task_start = wr_one & wr_to(PADDR, `OFS_TASK_START);
   wire task_stop = (wr_one & wr_to(PADDR, `OFS_TASK_STOP))
      | (link_reg[`LNK_SAMPLE_STOP] & p_smp)
      | (link_reg[`LNK_REPORT_STOP] & p_rep)
      | (link_reg[`LNK_DOUBLE_STOP] & p_dbl);
   wire task_clr_both = (wr_one & wr_to(PADDR, `OFS_TASK_CLR_BOTH))
      | (link_reg[`LNK_REPORT_CLR_BOTH] & p_rep)
      | (link_reg[`LNK_SAMPLE_CLR_BOTH] & p_smp);
   wire task_clr_mot = (wr_one & wr_to(PADDR, `OFS_TASK_CLR_MOTION))
      | (link_reg[`LNK_REPORT_CLR_MOTION] & p_rep);
   wire task_clr_dbl = (wr_one & wr_to(PADDR, `OFS_TASK_CLR_DOUBLES))
      | (link_reg[`LNK_DOUBLE_CLR_DOUBLES] & p_dbl);

   wire take_acc = task_clr_both | task_clr_mot;
   wire take_dbl = task_clr_both | task_clr_dbl;

   // accumulation; a sample arriving with a clear lands on the cleared value, so none is lost
   wire is_dbl = SAMPLE_VAL == `SAMPLE_DOUBLE;
   wire motion_stb = SAMPLE_STB & ~is_dbl;
   wire signed [ACC_W-1:0] acc_base = take_acc ? '0 : acc_reg;
   wire signed [ACC_W:0] acc_sum = {acc_base[ACC_W-1], acc_base}
      + {{(ACC_W-1){SAMPLE_VAL[1]}}, SAMPLE_VAL};
   wire acc_ovf = motion_stb & (acc_sum[ACC_W] ^ acc_sum[ACC_W-1]);
   assign acc_next = (motion_stb & ~acc_ovf) ? acc_sum[ACC_W-1:0] : acc_base;

   wire [DBL_W-1:0] dbl_base = take_dbl ? '0 : dbl_reg;
   wire dbl_full = &dbl_base;
   wire dbl_ovf = SAMPLE_STB & is_dbl & dbl_full;
   assign dbl_next = (SAMPLE_STB & is_dbl & ~dbl_full) ? dbl_base + 1'b1 : dbl_base;

   // report period; >= keeps a shortened period from overrunning
   wire [`RP_CNT_W-1:0] rp_last = period_samples(period_reg) - 1'b1;
   wire period_end = SAMPLE_STB & (rp_cnt_reg >= rp_last);
   assign rp_cnt_next = SAMPLE_STB ? (period_end ? '0 : rp_cnt_reg + 1'b1) : rp_cnt_reg;

   // run control
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (task_stop) begin
               state_next = ST_STOPPING;
            end else if (task_start) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (task_stop) begin
               state_next = ST_STOPPING;
            end
         end
         ST_STOPPING: begin
            if (CORE_HALTED) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   wire halted_now = (state_reg == ST_STOPPING) & CORE_HALTED;

   // event sources
   wire [`EV_NUM-1:0] ev_set;
   assign ev_set[`EV_SAMPLE] = SAMPLE_STB;
   assign ev_set[`EV_REPORT] = period_end & (acc_next != '0);
   assign ev_set[`EV_OVERFLOW] = acc_ovf | dbl_ovf;
   assign ev_set[`EV_DOUBLE] = period_end & (dbl_next != '0);
   assign ev_set[`EV_HALTED] = halted_now;

   // sticky events, hardware set wins over a software write in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < `EV_NUM; gi++) begin : g_ev
         assign ev_next[gi] = ev_set[gi] | (wr_ev[gi] ? PWDATA[0] : ev_reg[gi]);
      end
   endgenerate

   assign mask_next = wr_mset ? (mask_reg | PWDATA[`EV_NUM-1:0])
      : wr_mclr ? (mask_reg & ~PWDATA[`EV_NUM-1:0]) : mask_reg;

   // read mux, captured in the setup cycle and presented in the access cycle
   logic [31:0] rd_val;
   logic rd_miss;
   always_comb begin
      rd_val = `REG_RESET;
      rd_miss = 1'b0;
      case (PADDR)
         `OFS_TASK_START, `OFS_TASK_STOP, `OFS_TASK_CLR_BOTH,
         `OFS_TASK_CLR_MOTION, `OFS_TASK_CLR_DOUBLES: rd_val = `REG_RESET;
         `OFS_EV_SAMPLE_READY: rd_val = {31'h0, ev_reg[`EV_SAMPLE]};
         `OFS_EV_REPORT_READY: rd_val = {31'h0, ev_reg[`EV_REPORT]};
         `OFS_EV_OVERFLOW: rd_val = {31'h0, ev_reg[`EV_OVERFLOW]};
         `OFS_EV_DOUBLE_READY: rd_val = {31'h0, ev_reg[`EV_DOUBLE]};
         `OFS_EV_HALTED: rd_val = {31'h0, ev_reg[`EV_HALTED]};
         `OFS_LINKS: rd_val = {{(32-`LNK_NUM){1'b0}}, link_reg};
         `OFS_IRQ_SET, `OFS_IRQ_CLR: rd_val = {{(32-`EV_NUM){1'b0}}, mask_reg};
         `OFS_SAMPLE: begin
            if (sample_reg == `SAMPLE_DOUBLE) begin
               rd_val = `SAMPLE_DOUBLE_READ;
            end else begin
               rd_val = {{30{sample_reg[1]}}, sample_reg};
            end
         end
         `OFS_REPORT_PERIOD: rd_val = {{(32-`RP_CODE_W){1'b0}}, period_reg};
         `OFS_MOTION: rd_val = {{(32-ACC_W){acc_reg[ACC_W-1]}}, acc_reg};
         `OFS_MOTION_SNAP: rd_val = {{(32-ACC_W){snap_acc_reg[ACC_W-1]}}, snap_acc_reg};
         `OFS_DOUBLE_COUNT: rd_val = {{(32-DBL_W){1'b0}}, dbl_reg};
         `OFS_DOUBLE_SNAP: rd_val = {{(32-DBL_W){1'b0}}, snap_dbl_reg};
         default: rd_miss = 1'b1;
      endcase
   end

   // bus answer
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pready_reg <= 1'b0;
         prdata_reg <= `REG_RESET;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= apb_setup;
         pslverr_reg <= apb_setup & rd_miss;
         if (apb_setup) begin
            prdata_reg <= PWRITE ? `REG_RESET : rd_val;
         end
      end
   end

   // configuration
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         link_reg <= '0;
         period_reg <= `RP_RESET;
         mask_reg <= '0;
      end else begin
         if (wr_links) begin
            link_reg <= PWDATA[`LNK_NUM-1:0];
         end
         if (wr_period) begin
            period_reg <= PWDATA[`RP_CODE_W-1:0];
         end
         mask_reg <= mask_next;
      end
   end

   // accumulators and snapshots
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_reg <= '0;
         dbl_reg <= '0;
         snap_acc_reg <= '0;
         snap_dbl_reg <= '0;
         rp_cnt_reg <= '0;
         sample_reg <= '0;
      end else begin
         acc_reg <= acc_next;
         dbl_reg <= dbl_next;
         rp_cnt_reg <= rp_cnt_next;
         if (take_acc) begin
            snap_acc_reg <= acc_reg;
         end
         if (take_dbl) begin
            snap_dbl_reg <= dbl_reg;
         end
         if (SAMPLE_STB) begin
            sample_reg <= SAMPLE_VAL;
         end
      end
   end

   // events, run state, interrupt
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ev_reg <= '0;
         ev_pulse_reg <= '0;
         irq_reg <= 1'b0;
         run_reg <= 1'b0;
         state_reg <= ST_IDLE;
      end else begin
         ev_reg <= ev_next;
         ev_pulse_reg <= ev_set;
         irq_reg <= |(ev_next & mask_next);
         run_reg <= state_next == ST_RUN;
         state_reg <= state_next;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign DECODER_RUN = run_reg;
   assign IRQ = irq_reg;

   // checks
   snap_motion_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      take_acc |=> snap_acc_reg == $past(acc_reg))
      else $error("motion snapshot wrong");

   clr_doubles_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (take_dbl && !SAMPLE_STB) |=> dbl_reg == '0 && snap_dbl_reg == $past(dbl_reg))
      else $error("double clear wrong");

   sample_event_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      SAMPLE_STB |=> ev_reg[`EV_SAMPLE] && ev_pulse_reg[`EV_SAMPLE] && sample_reg == $past(SAMPLE_VAL))
      else $error("sample event missing");

   // a software write of one may also raise the bit, so only hardware rises are held to the rule
   report_event_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ($rose(ev_reg[`EV_REPORT]) && !$past(wr_ev[`EV_REPORT])) |-> $past(period_end) && acc_reg != '0)
      else $error("report event without motion");

   overflow_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (acc_ovf && !take_acc) |=> acc_reg == $past(acc_reg) && ev_reg[`EV_OVERFLOW])
      else $error("overflow not handled");

   double_event_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (period_end && dbl_next != '0) |=> ev_reg[`EV_DOUBLE])
      else $error("double event missing");

   halted_event_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ev_pulse_reg[`EV_HALTED] |-> state_reg == ST_IDLE && !run_reg)
      else $error("halted while running");

   link_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (link_reg[`LNK_SAMPLE_STOP] && p_smp && state_reg == ST_RUN) |=> state_reg == ST_STOPPING)
      else $error("link stop ignored");

   mask_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (wr_mset && PWDATA[`EV_REPORT]) |=> mask_reg[`EV_REPORT])
      else $error("mask set ignored");

   mask_clr_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (wr_mclr && PWDATA[`EV_OVERFLOW]) |=> !mask_reg[`EV_OVERFLOW])
      else $error("mask clear ignored");

   irq_level_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      IRQ == |(ev_reg & mask_reg))
      else $error("irq level mismatch");

   event_sticky_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (ev_reg[`EV_SAMPLE] && !wr_ev[`EV_SAMPLE]) |=> ev_reg[`EV_SAMPLE])
      else $error("event dropped");

   clr_both_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (task_clr_both && !SAMPLE_STB) |=> acc_reg == '0 && dbl_reg == '0
         && snap_acc_reg == $past(acc_reg) && snap_dbl_reg == $past(dbl_reg))
      else $error("clear both wrong");

   period_count_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      SAMPLE_STB |=> (rp_cnt_reg == '0) == $past(period_end))
      else $error("report period count wrong");

   report_quiet_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (period_end && acc_next == '0 && !ev_reg[`EV_REPORT] && !wr_ev[`EV_REPORT]) |=> !ev_reg[`EV_REPORT])
      else $error("empty report raised event");

   double_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (dbl_ovf && !take_dbl) |=> dbl_reg == $past(dbl_reg) && ev_reg[`EV_OVERFLOW])
      else $error("double overflow not handled");

endmodule // quadrature_decoder_events

// ---- hw/quadrature_decoder_pkg.sv ----
package quadrature_decoder_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_STOPPING = 3'b100
   } run_state_t;

endpackage

// ---- verif/quadrature_decoder_events_tb.sv ----
`timescale 1ns/1ps
`include "quadrature_decoder_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module quadrature_decoder_events_tb;
   logic clk = 1'b0;
   logic rst_n, psel, penable, pwrite, pready, pslverr, req, stb, halted, run, irq, err, stp;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] req_val, sval, v;
   int mismatches, check_count, seed, acc_m, dbl_m;
   logic [11:0] zr[14] = '{12'h100, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h200, 12'h304,
                           12'h308, 12'h50c, 12'h510, 12'h514, 12'h518, 12'h544, 12'h548};
   logic [1:0] lv[7] = '{2'b01, 2'b00, 2'b01, 2'b01, 2'b10, 2'b10, 2'b11};

   always #20 clk = ~clk;

   quadrature_decoder_events dut (
      .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SAMPLE_STB(stb), .SAMPLE_VAL(sval), .CORE_HALTED(halted), .DECODER_RUN(run), .IRQ(irq)
   );

   sampler_core_model core (
      .clk(clk), .rst_n(rst_n), .req(req), .req_val(req_val), .run(run),
      .stb(stb), .val(sval), .halted(halted)
   );

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         $display("mismatch at %0t: no ready", $time);
         mismatches++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask

   // one strobe from the core, then time for event and link to settle
   task automatic smp(input logic [1:0] s);
      @(posedge clk);
      req <= 1'b1;
      req_val <= s;
      @(posedge clk);
      req <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic clr_events();
      for (int i = 0; i < 5; i++) apb(1'b1, 12'h100 + 12'(4 * i), 32'h0000_0000);
   endtask

   task automatic wait_run(input logic want);
      int n;
      n = 0;
      while (run !== want && n < 64) begin
         @(posedge clk);
         n++;
      end
      if (run !== want) begin
         $display("mismatch at %0t: run state stuck", $time);
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      `CHK(irq, e)
   endtask

   function automatic int mot(input logic [1:0] s);
      return (s == 2'b01) ? 1 : (s == 2'b11) ? -1 : 0;
   endfunction

   initial begin
      #(40 * 100000);
      $display("mismatch at %0t: run too long", $time);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      seed = 91468;
      rst_n = 1'b0;
      {psel, penable, pwrite, req} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      req_val = 2'b00;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      foreach (zr[i]) rchk(zr[i], 32'h0000_0000);
      apb(1'b0, 12'h0fc, 32'h0000_0000);
      `CHK({err, rd}, 33'h1_0000_0000)
      // ten random samples at the reset period code
      apb(1'b1, `OFS_TASK_START, 32'h1);
      wait_run(1'b1);
      for (int i = 0; i < 10; i++) begin
         v = 2'($random(seed));
         smp(v);
         acc_m += mot(v);
         dbl_m += int'(v == 2'b10);
         if (i == 8) begin
            rchk(`OFS_EV_REPORT_READY, 32'h0);
            rchk(`OFS_EV_DOUBLE_READY, 32'h0);
         end
      end
      rchk(`OFS_EV_SAMPLE_READY, 32'h1);
      rchk(`OFS_SAMPLE, (v == 2'b11) ? 32'hffff_ffff : {30'h0, v});
      rchk(`OFS_EV_REPORT_READY, 32'(acc_m != 0));
      rchk(`OFS_EV_DOUBLE_READY, 32'(dbl_m != 0));
      rchk(`OFS_MOTION, 32'(acc_m));
      apb(1'b1, `OFS_TASK_CLR_MOTION, 32'h1);
      rchk(`OFS_MOTION_SNAP, 32'(acc_m));
      rchk(`OFS_MOTION, 32'h0);
      rchk(`OFS_DOUBLE_COUNT, 32'(dbl_m));
      apb(1'b1, `OFS_TASK_CLR_DOUBLES, 32'h1);
      rchk(`OFS_DOUBLE_SNAP, 32'(dbl_m));
      rchk(`OFS_DOUBLE_COUNT, 32'h0);
      // double counter saturates at 15, the sixteenth overflows
      clr_events();
      for (int i = 0; i < 15; i++) smp(2'b10);
      rchk(`OFS_EV_OVERFLOW, 32'h0);
      smp(2'b10);
      smp(2'b01);
      rchk(`OFS_EV_OVERFLOW, 32'h1);
      rchk(`OFS_DOUBLE_COUNT, 32'd15);
      apb(1'b1, `OFS_TASK_CLR_BOTH, 32'h1);
      rchk(`OFS_MOTION_SNAP, 32'h1);
      rchk(`OFS_DOUBLE_SNAP, 32'd15);
      rchk(`OFS_MOTION, 32'h0);
      rchk(`OFS_DOUBLE_COUNT, 32'h0);
      // motion accumulator tops out at 1023, the next step is dropped
      clr_events();
      for (int i = 0; i < 1023; i++) smp(2'b01);
      rchk(`OFS_EV_OVERFLOW, 32'h0);
      smp(2'b01);
      rchk(`OFS_EV_OVERFLOW, 32'h1);
      rchk(`OFS_MOTION, 32'd1023);
      // interrupt mask and line
      apb(1'b1, `OFS_IRQ_SET, 32'hffff_ffff);
      rchk(`OFS_IRQ_SET, 32'h1f);
      rchk(`OFS_IRQ_CLR, 32'h1f);
      apb(1'b1, `OFS_IRQ_CLR, 32'h1);
      apb(1'b1, `OFS_IRQ_SET, 32'h0);
      rchk(`OFS_IRQ_SET, 32'h1e);
      clr_events();
      irq_is(1'b0);
      apb(1'b1, `OFS_EV_SAMPLE_READY, 32'h1);
      irq_is(1'b0);
      apb(1'b1, `OFS_EV_REPORT_READY, 32'h1);
      irq_is(1'b1);
      apb(1'b1, `OFS_IRQ_CLR, 32'h2);
      irq_is(1'b0);
      apb(1'b1, `OFS_IRQ_SET, 32'h2);
      irq_is(1'b1);
      apb(1'b1, `OFS_IRQ_CLR, 32'h1f);
      // every link in turn, one sample per report
      apb(1'b1, `OFS_REPORT_PERIOD, 32'h8);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, `OFS_TASK_CLR_BOTH, 32'h1);
         clr_events();
         apb(1'b1, `OFS_TASK_START, 32'h1);
         wait_run(1'b1);
         apb(1'b1, `OFS_LINKS, 32'h1 << i);
         smp(lv[i]);
         repeat (8) @(posedge clk);
         apb(1'b1, `OFS_LINKS, 32'h0);
         stp = (i == 1 || i == 3 || i == 5);
         rchk(`OFS_MOTION, (i == 0 || i == 2 || i == 6) ? 32'h0 : 32'(mot(lv[i])));
         rchk(`OFS_DOUBLE_COUNT, (i == 0 || i == 4 || i == 6) ? 32'h0 : 32'(lv[i] == 2'b10));
         `CHK(run, !stp)
         rchk(`OFS_EV_HALTED, 32'(stp));
      end
      // forty samples at code one, the report comes only with the last
      apb(1'b1, `OFS_REPORT_PERIOD, 32'h1);
      clr_events();
      for (int i = 0; i < 40; i++) begin
         if (i == 39) begin
            rchk(`OFS_EV_REPORT_READY, 32'h0);
         end
         smp(2'b01);
      end
      rchk(`OFS_EV_REPORT_READY, 32'h1);
      rchk(`OFS_MOTION, 32'd40);
      tally_and_finish();
   end
endmodule // quadrature_decoder_events_tb

// ---- verif/sampler_core_model.sv ----
`timescale 1ns/1ps

module sampler_core_model #(
   parameter int HALT_LAT = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench request
   input wire logic req,
   input wire logic [1:0] req_val,
   // decoder side
   input wire logic run,
   output logic stb,
   output logic [1:0] val,
   output logic halted
);
   int halt_cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stb <= 1'b0;
         val <= 2'b00;
         halted <= 1'b1;
         halt_cnt <= 0;
      end else begin
         // a real core only produces samples while it is told to run
         stb <= req && run;
         // between strobes the value lines toggle, carrying the inverse of the last value and then the last value again
         val <= (req && run) ? req_val : ~val;
         if (run) begin
            halted <= 1'b0;
            halt_cnt <= 0;
         end else if (halt_cnt == HALT_LAT) begin
            halted <= 1'b1;
         end else begin
            halt_cnt <= halt_cnt + 1;
         end
      end
   end
endmodule // sampler_core_model
